// *** hw/sh_parity_pkg.sv ***
`default_nettype none
package sh_parity_pkg;
  localparam int unsigned BLK_W = 64;
  localparam int unsigned IDX_W = 5;
  localparam logic [4:0] LAST_BLK = 5'h1F;
  localparam logic [4:0] FIRST_BLK = 5'h00;
  localparam int unsigned CRC_W = 12;
  localparam int unsigned FEC_W = 26;
  // generator polynomials without the leading term
  localparam logic [11:0] CRC_POLY = 12'h30F;
  localparam logic [25:0] FEC_POLY = 26'h0220211;
  // stream positions
  localparam int unsigned EOEMB_POS = 22;
  localparam int unsigned PILOT_POS = 27;
  localparam int unsigned STREAM_W = 32;
  // fixed ones of the crc layout, pilot one included
  localparam logic [31:0] CRC_ONES = 32'h80A88888;
  // crc bit positions in the stream, parity bit 11 first
  localparam logic [31:0] CRC_SLOTS = 32'h00007777;
  // single multiblock per extended multiblock
  localparam logic EOEMB_VAL = 1'b1;
  // sync header codes: first bit sent is bit 1
  localparam logic [1:0] SH_ONE = 2'h1;
  localparam logic [1:0] SH_ZERO = 2'h2;
  // first-bit detection latency in blocks
  localparam int unsigned CRC_LAT_BLOCKS = 46;
  localparam int unsigned FEC_LAT_BLOCKS = 58;
endpackage : sh_parity_pkg
`default_nettype wire

// *** hw/sync_header_parity_stream.sv ***
`default_nettype none
module sync_header_parity_stream
  import sh_parity_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic link_en_i,
  input wire logic fec_mode_i,
  input wire logic blk_valid_i,
  input wire logic [63:0] blk_data_i,
  output logic blk_valid_o,
  output logic [63:0] blk_data_o,
  output logic [1:0] sync_hdr_o,
  output logic [4:0] blk_idx_o,
  output logic fec_active_o,
  output logic mb_end_o
);

  // one crc-12 step per block, data bit 63 enters first
  function automatic logic [11:0] crc_block(input logic [11:0] s, input logic [63:0] d);
    logic [11:0] r;
    logic fb;
    r = s;
    for (int i = BLK_W - 1; i >= 0; i--) begin
      fb = d[i] ^ r[CRC_W-1];
      r = {r[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : 12'h000);
    end
    return r;
  endfunction : crc_block

  // one fire-code step per block, same bit order
  function automatic logic [25:0] fec_block(input logic [25:0] s, input logic [63:0] d);
    logic [25:0] r;
    logic fb;
    r = s;
    for (int i = BLK_W - 1; i >= 0; i--) begin
      fb = d[i] ^ r[FEC_W-1];
      r = {r[FEC_W-2:0], 1'b0} ^ (fb ? FEC_POLY : 26'h0000000);
    end
    return r;
  endfunction : fec_block

  // lay the held parity out as a 32-bit stream word
  function automatic logic [31:0] build_stream(input logic [25:0] p, input logic fec);
    logic [31:0] w;
    int k;
    w = 32'h00000000;
    k = CRC_W - 1;
    if (fec) begin
      for (int i = 0; i < EOEMB_POS; i++) begin
        w[i] = p[FEC_W-1-i];
      end
      for (int i = EOEMB_POS + 1; i < PILOT_POS; i++) begin
        w[i] = p[PILOT_POS-1-i];
      end
      w[STREAM_W-1] = 1'b1;
    end else begin
      for (int i = 0; i < EOEMB_POS; i++) begin
        if (CRC_SLOTS[i]) begin
          w[i] = p[k];
          k = k - 1;
        end
      end
      w = w | CRC_ONES;
    end
    w[EOEMB_POS] = EOEMB_VAL;
    return w;
  endfunction : build_stream

  // stream bit to two-bit header code, shared by the header path and the checks
  function automatic logic [1:0] sh_enc(input logic b);
    return b ? SH_ONE : SH_ZERO;
  endfunction : sh_enc

  logic [4:0] idx_q, idx_d;
  logic fec_q;
  logic [25:0] state_q, state_d;
  logic [25:0] hold_q, hold_d;
  logic [1:0] sh_q;
  logic [63:0] data_q;
  logic valid_q, mb_end_q;
  logic [4:0] oidx_q;
  logic ofec_q;

  // mode only changes at a multiblock edge, so one parity never mixes codes
  wire logic take = blk_valid_i & link_en_i;
  wire logic first_blk = (idx_q == FIRST_BLK);
  wire logic last_blk = (idx_q == LAST_BLK);
  wire logic eff_fec = first_blk ? fec_mode_i : fec_q;
  // state seeds from zero on the first block of every multiblock
  wire logic [25:0] seed = first_blk ? 26'h0000000 : state_q;
  wire logic [11:0] crc_next = crc_block(seed[11:0], blk_data_i);
  wire logic [25:0] fec_next = fec_block(seed, blk_data_i);
  wire logic [25:0] par_next = eff_fec ? fec_next : {14'h0000, crc_next};
  wire logic [31:0] stream = build_stream(hold_q, eff_fec);
  wire logic sh_bit = stream[idx_q];
  wire logic [1:0] sh_code = sh_enc(sh_bit);

  // counter and parity state advance only on accepted blocks
  always_comb begin
    idx_d = idx_q;
    state_d = state_q;
    hold_d = hold_q;
    if (take) begin
      idx_d = 5'(idx_q + 5'h01);
      state_d = par_next;
      if (last_blk) begin
        hold_d = par_next;
      end
    end
  end

  // disabled link restarts at block 0 with empty parity
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || !link_en_i) begin
      idx_q <= FIRST_BLK;
      fec_q <= 1'b0;
      state_q <= 26'h0000000;
      hold_q <= 26'h0000000;
    end else begin
      idx_q <= idx_d;
      fec_q <= take ? eff_fec : fec_q;
      state_q <= state_d;
      hold_q <= hold_d;
    end
  end

  // output stage: header, block and position leave together
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      valid_q <= 1'b0;
      data_q <= 64'h0000000000000000;
      sh_q <= SH_ZERO;
      oidx_q <= FIRST_BLK;
      ofec_q <= 1'b0;
      mb_end_q <= 1'b0;
    end else begin
      valid_q <= take;
      data_q <= take ? blk_data_i : data_q;
      sh_q <= take ? sh_code : sh_q;
      oidx_q <= take ? idx_q : oidx_q;
      ofec_q <= take ? eff_fec : ofec_q;
      mb_end_q <= take & last_blk;
    end
  end

  assign blk_valid_o = valid_q;
  assign blk_data_o = data_q;
  assign sync_hdr_o = sh_q;
  assign blk_idx_o = oidx_q;
  assign fec_active_o = ofec_q;
  assign mb_end_o = mb_end_q;

  // ---- checks ----
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_pilot_tail: assert property (blk_valid_o && blk_idx_o >= 5'(PILOT_POS) |->
    sync_hdr_o == ((blk_idx_o == LAST_BLK) ? SH_ONE : SH_ZERO))
    else $error("pilot tail wrong");

  a_eoemb_set: assert property (blk_valid_o && blk_idx_o == 5'(EOEMB_POS) |-> sync_hdr_o == SH_ONE)
    else $error("end of extended multiblock bit not set");

  a_crc_ones: assert property (blk_valid_o && !fec_active_o && blk_idx_o[1:0] == 2'h3
    && blk_idx_o <= 5'h17 |-> sync_hdr_o == SH_ONE)
    else $error("fixed one missing in crc stream");

  a_cmd_zero: assert property (blk_valid_o && !fec_active_o && (blk_idx_o inside {5'h10, 5'h11, 5'h12,
    5'h14, 5'h18, 5'h19, 5'h1A}) |-> sync_hdr_o == SH_ZERO)
    else $error("command bit not zero");

  a_crc_msb_first: assert property (take && !eff_fec && first_blk |=>
    sync_hdr_o == ($past(hold_q[11]) ? SH_ONE : SH_ZERO))
    else $error("crc msb not at position 0");

  a_fec_map: assert property (take && eff_fec && idx_q == 5'h1A |=>
    sync_hdr_o == ($past(hold_q[0]) ? SH_ONE : SH_ZERO))
    else $error("fec bit 0 not at position 26");

  sequence s_first_taken;
    take && first_blk;
  endsequence
  a_state_cleared: assert property (s_first_taken |=>
    state_q == (fec_q ? fec_block(26'h0000000, $past(blk_data_i))
      : {14'h0000, crc_block(12'h000, $past(blk_data_i[63:0]))}))
    else $error("parity state not cleared at multiblock start");

  sequence s_last_taken;
    take && last_blk;
  endsequence
  a_hold_next_mb: assert property (s_last_taken |=> hold_q == $past(par_next) ##1
    (hold_q == $past(hold_q) || !link_en_i))
    else $error("parity not held for following multiblock");

  // mode on the outputs never moves between blocks of one multiblock
  a_mode_stable: assert property (take && !first_blk |=> fec_active_o == $past(fec_active_o))
    else $error("mode changed inside multiblock");

  // ---- output stage follows each accepted block ----
  // a lost or doubled valid would shift every later stream position
  a_valid_follow: assert property (take |=> blk_valid_o)
    else $error("accepted block not shown");

  a_no_spurious: assert property (!take |=> !blk_valid_o)
    else $error("valid without accepted block");

  // position travels with its block
  a_idx_follow: assert property (take |=> blk_idx_o == $past(idx_q))
    else $error("block index not carried");

  // payload passes untouched; parity never rides inside it
  a_data_follow: assert property (take |=> blk_data_o == $past(blk_data_i))
    else $error("block data not carried");

  // shown mode is the one the parity path used
  a_mode_follow: assert property (take |=> fec_active_o == $past(eff_fec))
    else $error("mode output not carried");

  // only the two legal header codes ever leave
  a_hdr_legal: assert property (blk_valid_o |-> (sync_hdr_o == SH_ONE || sync_hdr_o == SH_ZERO))
    else $error("illegal sync header code");

  // end pulse marks exactly the final block
  a_mb_end_match: assert property (mb_end_o == (blk_valid_o && blk_idx_o == LAST_BLK))
    else $error("multiblock end pulse misplaced");

  // a disabled link leaves no stale parity for the restart
  a_disable_restart: assert property (!link_en_i |=>
    idx_q == FIRST_BLK && state_q == 26'h0000000 && hold_q == 26'h0000000)
    else $error("disable did not restart the multiblock");

  // crc mode holds a 12-bit word only, no short variant
  a_no_crc3: assert property (take && last_blk && !eff_fec |=> hold_q[25:12] == 14'h0000)
    else $error("crc parity wider than twelve bits");

  // ---- per-position stream mapping ----
  // a wrong slot still gives a legal pilot, so every crc slot and eight fec slots are pinned
  sequence s_crc_at(logic [4:0] pos);
    take && !eff_fec && idx_q == pos;
  endsequence
  sequence s_fec_at(logic [4:0] pos);
    take && eff_fec && idx_q == pos;
  endsequence

  // crc first group, after the msb at position 0
  a_crc_pos1: assert property (s_crc_at(5'h01) |=> sync_hdr_o == sh_enc($past(hold_q[10])))
    else $error("crc bit 10 not at position 1");

  a_crc_pos2: assert property (s_crc_at(5'h02) |=> sync_hdr_o == sh_enc($past(hold_q[9])))
    else $error("crc bit 9 not at position 2");

  // crc second group
  a_crc_pos4: assert property (s_crc_at(5'h04) |=> sync_hdr_o == sh_enc($past(hold_q[8])))
    else $error("crc bit 8 not at position 4");

  a_crc_pos5: assert property (s_crc_at(5'h05) |=> sync_hdr_o == sh_enc($past(hold_q[7])))
    else $error("crc bit 7 not at position 5");

  a_crc_pos6: assert property (s_crc_at(5'h06) |=> sync_hdr_o == sh_enc($past(hold_q[6])))
    else $error("crc bit 6 not at position 6");

  // crc third group
  a_crc_pos8: assert property (s_crc_at(5'h08) |=> sync_hdr_o == sh_enc($past(hold_q[5])))
    else $error("crc bit 5 not at position 8");

  a_crc_pos9: assert property (s_crc_at(5'h09) |=> sync_hdr_o == sh_enc($past(hold_q[4])))
    else $error("crc bit 4 not at position 9");

  a_crc_pos10: assert property (s_crc_at(5'h0A) |=> sync_hdr_o == sh_enc($past(hold_q[3])))
    else $error("crc bit 3 not at position 10");

  // crc last group; bit 0 lands the fixed detection latency after the first data bit
  a_crc_pos12: assert property (s_crc_at(5'h0C) |=> sync_hdr_o == sh_enc($past(hold_q[2])))
    else $error("crc bit 2 not at position 12");

  a_crc_pos13: assert property (s_crc_at(5'h0D) |=> sync_hdr_o == sh_enc($past(hold_q[1])))
    else $error("crc bit 1 not at position 13");

  a_crc_latency: assert property (s_crc_at(5'(CRC_LAT_BLOCKS - STREAM_W)) |=>
    sync_hdr_o == sh_enc($past(hold_q[0])))
    else $error("crc bit 0 not at latency position");

  // the fixed one at 21 that the nibble check skips; the one at 31 is left to the pilot tail check
  a_crc_fixed21: assert property (s_crc_at(5'h15) |=> sync_hdr_o == SH_ONE)
    else $error("fixed one missing at position 21");

  // fec: msb first, no fixed ones inside the parity run
  a_fec_pos0: assert property (s_fec_at(5'h00) |=> sync_hdr_o == sh_enc($past(hold_q[25])))
    else $error("fec bit 25 not at position 0");

  a_fec_pos3: assert property (s_fec_at(5'h03) |=> sync_hdr_o == sh_enc($past(hold_q[22])))
    else $error("fec bit 22 not at position 3");

  a_fec_pos8: assert property (s_fec_at(5'h08) |=> sync_hdr_o == sh_enc($past(hold_q[17])))
    else $error("fec bit 17 not at position 8");

  a_fec_pos13: assert property (s_fec_at(5'h0D) |=> sync_hdr_o == sh_enc($past(hold_q[12])))
    else $error("fec bit 12 not at position 13");

  a_fec_pos17: assert property (s_fec_at(5'h11) |=> sync_hdr_o == sh_enc($past(hold_q[8])))
    else $error("fec bit 8 not at position 17");

  // around the end-of-extended flag the parity run splits
  a_fec_pos21: assert property (s_fec_at(5'h15) |=> sync_hdr_o == sh_enc($past(hold_q[4])))
    else $error("fec bit 4 not at position 21");

  a_fec_pos23: assert property (s_fec_at(5'h17) |=> sync_hdr_o == sh_enc($past(hold_q[3])))
    else $error("fec bit 3 not at position 23");

  // last fec bit sets the correction latency seen by the receiver
  a_fec_latency: assert property (s_fec_at(5'(FEC_LAT_BLOCKS - STREAM_W)) |=>
    sync_hdr_o == sh_enc($past(hold_q[0])))
    else $error("fec bit 0 not at latency position");

endmodule : sync_header_parity_stream
`default_nettype wire

// *** bench/sh_rx_model.sv ***
`default_nettype none
module sh_rx_model
  import sh_parity_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic blk_valid_i,
  input wire logic [63:0] blk_data_i,
  input wire logic [1:0] sync_hdr_i,
  input wire logic [4:0] blk_idx_i,
  input wire logic fec_i,
  output logic [31:0] stream_o,
  output logic [25:0] par_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] st_q;
  logic [25:0] lf_q;
  // one galois step; crc state lives in the low 12 bits
  function automatic logic [25:0] lfsr_step(input logic [25:0] s, input logic d, input logic f);
    logic fb;
    fb = d ^ (f ? s[25] : s[11]);
    lfsr_step = f ? {s[24:0], 1'b0} ^ (fb ? FEC_POLY : 26'h0)
              : {14'h0, s[10:0], 1'b0} ^ {14'h0, (fb ? CRC_POLY : 12'h0)};
  endfunction : lfsr_step
  // gather stream bits and recompute parity per multiblock, msb of data first
  always @(posedge core_clk_i) begin
    if (blk_valid_i) begin
      st_q[blk_idx_i] = (sync_hdr_i == SH_ONE);
      if (blk_idx_i == FIRST_BLK) lf_q = 26'h0;
      for (int i = 63; i >= 0; i--) lf_q = lfsr_step(lf_q, blk_data_i[i], fec_i);
      if (blk_idx_i == LAST_BLK) begin
        stream_o <= st_q;
        par_o <= lf_q;
      end
    end
  end
endmodule : sh_rx_model
`default_nettype wire

// *** bench/test_sync_header_parity_stream.sv ***
`default_nettype none
module test_sync_header_parity_stream
  import sh_parity_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, link_en_i = 1'b1, fec_mode_i = 1'b0, blk_valid_i = 1'b0;
  logic [63:0] blk_data_i = 64'h0, blk_data_o;
  logic blk_valid_o, fec_active_o, mb_end_o;
  logic [1:0] sync_hdr_o;
  logic [4:0] blk_idx_o;
  logic [31:0] stream;
  logic [25:0] par;
  int err_count = 0, compares = 0, n = 0, cyc = 0;
  sync_header_parity_stream DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link_en_i(link_en_i),
    .fec_mode_i(fec_mode_i), .blk_valid_i(blk_valid_i), .blk_data_i(blk_data_i), .blk_valid_o(blk_valid_o),
    .blk_data_o(blk_data_o), .sync_hdr_o(sync_hdr_o), .blk_idx_o(blk_idx_o), .fec_active_o(fec_active_o),
    .mb_end_o(mb_end_o));
  sh_rx_model rx (.core_clk_i(core_clk_i), .blk_valid_i(blk_valid_o), .blk_data_i(blk_data_o),
    .sync_hdr_i(sync_hdr_o), .blk_idx_i(blk_idx_o), .fec_i(fec_active_o), .stream_o(stream), .par_o(par));
  // 250 MHz clock
  always #2 core_clk_i = ~core_clk_i;
  // hang guard, far above the roughly 180 cycles the run needs
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // expected stream word from the previous multiblock's parity
  function automatic logic [31:0] exp_st(input logic [25:0] p, input logic f);
    logic [31:0] s;
    s = 32'h80400000;
    if (f) for (int i = 0; i < 27; i++) s[i] = (i < 22) ? p[25-i] : (i > 22) ? p[26-i] : 1'b1;
    else begin
      for (int g = 0; g < 12; g++) s[g + g/3] = p[11-g];
      s = s | 32'h00A88888;
    end
    return s;
  endfunction : exp_st
  // places where the end pilot pattern shows up in a stream word
  function automatic int pilot_hits(input logic [31:0] s);
    int c;
    c = 0;
    for (int j = 0; j < 28; j++) if (s[j+:5] == 5'h10) c++;
    return c;
  endfunction : pilot_hits
  // received fec parity pulled back out of the stream
  function automatic logic [25:0] fec_par(input logic [31:0] s);
    logic [25:0] p;
    for (int i = 0; i < 22; i++) p[25-i] = s[i];
    for (int i = 23; i < 27; i++) p[26-i] = s[i];
    return p;
  endfunction : fec_par
  // one block, checked on the cycle its result stands
  task automatic blk(input logic [4:0] i, input logic f);
    logic [63:0] d;
    d = 64'h9E3779B97F4A7C15 * (n + 1);
    n++;
    blk_data_i = d;
    blk_valid_i = 1'b1;
    @(negedge core_clk_i);
    chk("valid", 64'h1, 64'(blk_valid_o));
    chk("data", d, blk_data_o);
    chk("hdr_legal", 64'h1, 64'(sync_hdr_o == SH_ONE || sync_hdr_o == SH_ZERO));
    chk("idx", 64'(i), 64'(blk_idx_o));
    chk("mode", 64'(f), 64'(fec_active_o));
    chk("mb_end", 64'(i == LAST_BLK), 64'(mb_end_o));
  endtask : blk
  // a back-to-back multiblock; tog flips the mode input at that block
  task automatic mb(input logic f, input int tog, input logic ck, input logic [25:0] pv);
    for (int i = 0; i < 32; i++) begin
      if (i == tog) fec_mode_i = ~fec_mode_i;
      blk(5'(i), f);
    end
    blk_valid_i = 1'b0;
    @(negedge core_clk_i);
    chk("valid_drop", 64'h0, 64'(blk_valid_o));
    if (ck) chk("stream", 64'(exp_st(pv, f)), 64'(stream));
    if (ck && !f) chk("pilot_unique", 64'h1, 64'(pilot_hits(stream) == 1));
    if (ck && f) chk("pilot_tail", 64'h10, 64'(stream[31:27]));
    if (ck && f) chk("syndrome", 64'h0, 64'(fec_par(stream) ^ pv));
  endtask : mb
  task automatic t_reset();
    chk("rst_valid", 64'h0, 64'(blk_valid_o));
    chk("rst_hdr", 64'(SH_ZERO), 64'(sync_hdr_o));
    chk("rst_end", 64'h0, 64'(mb_end_o));
    chk("rst_data", 64'h0, blk_data_o);
    chk("rst_idx", 64'h0, 64'(blk_idx_o));
    chk("rst_mode", 64'h0, 64'(fec_active_o));
  endtask : t_reset
  // crc, with a mode change that must wait for the boundary
  task automatic t_crc();
    mb(1'b0, -1, 1'b1, 26'h0);
    mb(1'b0, 5, 1'b1, par);
  endtask : t_crc
  task automatic t_fec();
    mb(1'b1, -1, 1'b0, par);
    mb(1'b1, -1, 1'b1, par);
  endtask : t_fec
  // disable mid-multiblock: blocks refused, restart at block 0 with zero parity
  task automatic t_dis();
    for (int i = 0; i < 9; i++) blk(5'(i), 1'b1);
    link_en_i = 1'b0;
    repeat (2) begin
      @(negedge core_clk_i);
      chk("refused", 64'h0, 64'(blk_valid_o));
    end
    link_en_i = 1'b1;
    fec_mode_i = 1'b0;
    mb(1'b0, -1, 1'b1, 26'h0);
  endtask : t_dis
  initial begin
    repeat (4) @(negedge core_clk_i);
    t_reset();
    rst_n_i = 1'b1;
    t_crc();
    t_fec();
    t_dis();
    wrap_up();
  end
endmodule : test_sync_header_parity_stream
`default_nettype wire
